// ### hw/sac_lock_reg.sv
// Purpose: One lockable configuration field with an optional retained behaviour.
// Assumes: Caller raises wr_en_in for one cycle with the merged write value.
// Notes:   A retained field ignores the soft clear and only the hard reset clears it.
`timescale 1ns/1ps
`default_nettype none
module sac_lock_reg #(
  parameter int           W      = 1,
  parameter logic [W-1:0] RST    = '0,
  parameter bit           RETAIN = 1'b0
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         soft_clr_in,
  input  wire logic         wr_en_in,
  input  wire logic         locked_in,
  input  wire logic [W-1:0] wdata_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] field_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      field_r <= RST;
    end else if (soft_clr_in && !RETAIN) begin
      field_r <= RST;
    end else if (wr_en_in && !locked_in) begin
      field_r <= wdata_in;
    end
  end

  assign q_out = field_r;

endmodule
`default_nettype wire

// ### hw/sac_pkg.sv
// Purpose: Shared constants and carriers for the security attribute configuration block.
// Assumes: Registers are reached by 12-bit Avalon-MM byte addresses, one aligned 32-bit word each.
// Notes:   Instance counts are package constants because the packed carriers are sized by them.
package sac_pkg;

  localparam int SAC_ADDR_W   = 12;
  localparam int SAC_DATA_W   = 32;
  localparam int SAC_BE_W     = SAC_DATA_W / 8;

  // Instance counts of each register group, with channel and pin counts per register.
  localparam int SAC_EXT_N    = 1;
  localparam int SAC_EVT_N    = 1;
  localparam int SAC_EVT_CH   = 32;
  localparam int SAC_PORT_N   = 2;
  localparam int SAC_PIN_N    = 32;
  localparam int SAC_WIN_N    = 2;

  // Register offsets and instance strides.
  localparam logic [SAC_ADDR_W-1:0] SAC_EXT_PERMISSION_OFS   = 12'h440;
  localparam logic [SAC_ADDR_W-1:0] SAC_EXT_STRIDE     = 12'h004;
  localparam logic [SAC_ADDR_W-1:0] SAC_EVT_PERMISSION_OFS   = 12'h480;
  localparam logic [SAC_ADDR_W-1:0] SAC_EVT_LOCK_OFS   = 12'h484;
  localparam logic [SAC_ADDR_W-1:0] SAC_EVT_STRIDE     = 12'h008;
  localparam logic [SAC_ADDR_W-1:0] SAC_PORT_PERMISSION_OFS  = 12'h4C0;
  localparam logic [SAC_ADDR_W-1:0] SAC_PORT_LOCK_OFS  = 12'h4C4;
  localparam logic [SAC_ADDR_W-1:0] SAC_PORT_STRIDE    = 12'h008;
  localparam logic [SAC_ADDR_W-1:0] SAC_WIN_REGION_OFS = 12'h500;
  localparam logic [SAC_ADDR_W-1:0] SAC_WIN_SIZE_OFS   = 12'h504;
  localparam logic [SAC_ADDR_W-1:0] SAC_WIN_STRIDE     = 12'h008;

  // External domain permission fields.
  localparam int SAC_EXT_CAP_LSB  = 0;
  localparam int SAC_EXT_CAP_W    = 2;
  localparam int SAC_EXT_ATTR_BIT = 4;
  localparam int SAC_EXT_LOCK_BIT = 8;

  // Capability codes of the read-only field.
  typedef enum logic [SAC_EXT_CAP_W-1:0] {
    SAC_CAP_NON_SECURE = 2'b00,
    SAC_CAP_SECURE     = 2'b01,
    SAC_CAP_SW_SEL     = 2'b10
  } sac_cap_t;

  // Lock registers: one set-only bit.
  localparam int SAC_LOCK_BIT = 0;

  // Flash callable window fields.
  localparam int SAC_WIN_REGION_W = 6;
  localparam int SAC_WIN_SIZE_W   = 4;
  localparam int SAC_WIN_LOCK_BIT = 8;
  localparam int SAC_WIN_BYTES_W  = 13;
  localparam logic [SAC_WIN_SIZE_W-1:0]  SAC_WIN_SIZE_OFF   = 4'h0;
  localparam logic [SAC_WIN_SIZE_W-1:0]  SAC_WIN_SIZE_MAX   = 4'h8;
  localparam logic [SAC_WIN_SIZE_W-1:0]  SAC_WIN_SIZE_ONE   = 4'h1;
  localparam logic [SAC_WIN_BYTES_W-1:0] SAC_WIN_MIN_BYTES  = 13'h0020;

  // Reset values.
  localparam logic [SAC_EVT_CH-1:0]       SAC_EVT_PERMISSION_RST   = 32'h00000000;
  localparam logic [SAC_PIN_N-1:0]        SAC_PORT_PERMISSION_RST  = 32'h00000000;
  localparam logic [SAC_WIN_REGION_W-1:0] SAC_WIN_REGION_RST = 6'h00;
  localparam logic [SAC_WIN_SIZE_W-1:0]   SAC_WIN_SIZE_RST   = 4'h0;
  localparam logic                        SAC_EXT_ATTR_RST   = 1'b0;

  typedef struct packed {
    logic                  read;
    logic                  write;
    logic [SAC_ADDR_W-1:0] address;
    logic [SAC_DATA_W-1:0] writedata;
    logic [SAC_BE_W-1:0]   byteenable;
  } sac_avm_req_t;

  typedef struct packed {
    logic [SAC_EXT_N-1:0]                        ext_secure;
    logic [SAC_EVT_N-1:0][SAC_EVT_CH-1:0]        evt_secure;
    logic [SAC_PORT_N-1:0][SAC_PIN_N-1:0]        pin_secure;
    logic [SAC_WIN_N-1:0]                        win_enable;
    logic [SAC_WIN_N-1:0][SAC_WIN_REGION_W-1:0]  win_region;
    logic [SAC_WIN_N-1:0][SAC_WIN_BYTES_W-1:0]   win_bytes;
  } sac_attr_t;

endpackage

// ### hw/sac_top.sv
// Purpose: Security attribute configuration registers behind an Avalon-MM slave.
// Assumes: One clock; soft_reset_in is a synchronous system reset on ref_clk_in.
// Notes:   Attributes leave as levels decoded straight from the register flops.
// What this block does
// - Every external-domain access carries a security attribute.
// - Capability field reads non-secure, secure, or selectable.
// - Capability affects bus accesses, not event channels.
// - Attribute bit counts only when capability is selectable.
// - Selectable bit one means secure, zero non-secure.
// - External domain lock freezes register until reset.
// - Event permission register picks per-channel attribute.
// - Set lock blocks event and pin permission writes.
// - Per-port register holds one attribute bit per pin.
// - Pin permission registers survive soft system reset.
// - Region register selects flash region for window.
// - Size codes one to eight mean 32..4096 bytes.
// - Size zero disables the callable window.
// - Window size lock freezes content until reset.
`timescale 1ns/1ps
`default_nettype none
module sac_top
  import sac_pkg::*;
#(
  parameter sac_cap_t EXT_CAPABILITY = SAC_CAP_SW_SEL
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  soft_reset_in,
  input  wire sac_avm_req_t          avm_req_in,
  output logic                       avm_waitrequest_out,
  output logic      [SAC_DATA_W-1:0] avm_readdata_out,
  output sac_attr_t                  attr_out
);

  logic                  bus_req;
  logic                  bus_ack_r;
  logic                  wr_fire;
  logic [SAC_DATA_W-1:0] rd_val;
  logic [SAC_DATA_W-1:0] wr_merged;
  logic [SAC_DATA_W-1:0] be_mask;
  logic [SAC_DATA_W-1:0] readdata_r;

  logic [SAC_EXT_N-1:0]  ext_hit;
  logic [SAC_EVT_N-1:0]  evt_permission_hit;
  logic [SAC_EVT_N-1:0]  evt_lock_hit;
  logic [SAC_PORT_N-1:0] port_permission_hit;
  logic [SAC_PORT_N-1:0] port_lock_hit;
  logic [SAC_WIN_N-1:0]  win_region_hit;
  logic [SAC_WIN_N-1:0]  win_size_hit;

  logic [SAC_EXT_N-1:0]  ext_attr;
  logic [SAC_EXT_N-1:0]  ext_lock_r;
  logic [SAC_EVT_N-1:0][SAC_EVT_CH-1:0]       evt_permission;
  logic [SAC_EVT_N-1:0]                       evt_lock_r;
  logic [SAC_PORT_N-1:0][SAC_PIN_N-1:0]       port_permission;
  logic [SAC_PORT_N-1:0]                      port_lock_r;
  logic [SAC_WIN_N-1:0][SAC_WIN_REGION_W-1:0] win_region;
  logic [SAC_WIN_N-1:0][SAC_WIN_SIZE_W-1:0]   win_size;
  logic [SAC_WIN_N-1:0]                       win_lock_r;

  // The slave answers one cycle after a request appears; the ack flop drops
  // again at once so a held request is taken at most every second cycle.
  assign bus_req             = avm_req_in.read | avm_req_in.write;
  assign avm_waitrequest_out = bus_req & ~bus_ack_r;
  assign wr_fire             = avm_req_in.write & bus_ack_r;
  assign avm_readdata_out    = readdata_r;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_ack_r <= 1'b0;
    end else begin
      bus_ack_r <= bus_req & ~bus_ack_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      readdata_r <= '0;
    end else if (avm_req_in.read && !bus_ack_r) begin
      readdata_r <= rd_val;
    end
  end

  // Byte lanes not enabled keep the current content of the addressed word.
  always_comb begin
    be_mask = '0;
    for (int b = 0; b < SAC_BE_W; b++) begin
      be_mask[b*8 +: 8] = {8{avm_req_in.byteenable[b]}};
    end
    wr_merged = (avm_req_in.writedata & be_mask) | (rd_val & ~be_mask);
  end

  // External domain permission registers.
  genvar n;
  generate
    for (n = 0; n < SAC_EXT_N; n++) begin : g_ext
      assign ext_hit[n] = avm_req_in.address ==
                          SAC_EXT_PERMISSION_OFS + SAC_ADDR_W'(n) * SAC_EXT_STRIDE;

      // The capability field has no storage, so writes to it vanish.
      sac_lock_reg #(
        .W      (1),
        .RST    (SAC_EXT_ATTR_RST),
        .RETAIN (1'b0)
      ) u_ext_attr (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .soft_clr_in (soft_reset_in),
        .wr_en_in    (wr_fire && ext_hit[n]),
        .locked_in   (ext_lock_r[n]),
        .wdata_in    (wr_merged[SAC_EXT_ATTR_BIT]),
        .q_out       (ext_attr[n])
      );

      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          ext_lock_r[n] <= 1'b0;
        end else if (soft_reset_in) begin
          ext_lock_r[n] <= 1'b0;
        end else if (wr_fire && ext_hit[n] && wr_merged[SAC_EXT_LOCK_BIT]) begin
          ext_lock_r[n] <= 1'b1;
        end
      end

      // Only the capability decides whether the stored bit is used; event
      // channels of this domain take nothing from it.
      always_comb begin
        unique case (EXT_CAPABILITY)
          SAC_CAP_NON_SECURE: attr_out.ext_secure[n] = 1'b0;
          SAC_CAP_SECURE:     attr_out.ext_secure[n] = 1'b1;
          SAC_CAP_SW_SEL:     attr_out.ext_secure[n] = ext_attr[n];
          default:            attr_out.ext_secure[n] = 1'b0;
        endcase
      end
    end

    // Event interconnect permission and lock pairs.
    for (n = 0; n < SAC_EVT_N; n++) begin : g_evt
      assign evt_permission_hit[n] = avm_req_in.address ==
                               SAC_EVT_PERMISSION_OFS + SAC_ADDR_W'(n) * SAC_EVT_STRIDE;
      assign evt_lock_hit[n] = avm_req_in.address ==
                               SAC_EVT_LOCK_OFS + SAC_ADDR_W'(n) * SAC_EVT_STRIDE;

      sac_lock_reg #(
        .W      (SAC_EVT_CH),
        .RST    (SAC_EVT_PERMISSION_RST),
        .RETAIN (1'b0)
      ) u_evt_permission (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .soft_clr_in (soft_reset_in),
        .wr_en_in    (wr_fire && evt_permission_hit[n]),
        .locked_in   (evt_lock_r[n]),
        .wdata_in    (wr_merged[SAC_EVT_CH-1:0]),
        .q_out       (evt_permission[n])
      );

      // Writing zero to a lock is ignored; only reset clears it.
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          evt_lock_r[n] <= 1'b0;
        end else if (soft_reset_in) begin
          evt_lock_r[n] <= 1'b0;
        end else if (wr_fire && evt_lock_hit[n] && wr_merged[SAC_LOCK_BIT]) begin
          evt_lock_r[n] <= 1'b1;
        end
      end

      assign attr_out.evt_secure[n] = evt_permission[n];
    end

    // I/O port pin permission and lock pairs.
    for (n = 0; n < SAC_PORT_N; n++) begin : g_port
      assign port_permission_hit[n] = avm_req_in.address ==
                                SAC_PORT_PERMISSION_OFS + SAC_ADDR_W'(n) * SAC_PORT_STRIDE;
      assign port_lock_hit[n] = avm_req_in.address ==
                                SAC_PORT_LOCK_OFS + SAC_ADDR_W'(n) * SAC_PORT_STRIDE;

      // Retained: a soft system reset leaves the pin attributes in place, but
      // the lock still falls, so software must re-lock after it.
      sac_lock_reg #(
        .W      (SAC_PIN_N),
        .RST    (SAC_PORT_PERMISSION_RST),
        .RETAIN (1'b1)
      ) u_port_permission (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .soft_clr_in (soft_reset_in),
        .wr_en_in    (wr_fire && port_permission_hit[n]),
        .locked_in   (port_lock_r[n]),
        .wdata_in    (wr_merged[SAC_PIN_N-1:0]),
        .q_out       (port_permission[n])
      );

      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          port_lock_r[n] <= 1'b0;
        end else if (soft_reset_in) begin
          port_lock_r[n] <= 1'b0;
        end else if (wr_fire && port_lock_hit[n] && wr_merged[SAC_LOCK_BIT]) begin
          port_lock_r[n] <= 1'b1;
        end
      end

      assign attr_out.pin_secure[n] = port_permission[n];
    end

    // Flash non-secure callable windows.
    for (n = 0; n < SAC_WIN_N; n++) begin : g_win
      assign win_region_hit[n] = avm_req_in.address ==
                                 SAC_WIN_REGION_OFS + SAC_ADDR_W'(n) * SAC_WIN_STRIDE;
      assign win_size_hit[n]   = avm_req_in.address ==
                                 SAC_WIN_SIZE_OFS + SAC_ADDR_W'(n) * SAC_WIN_STRIDE;

      // The size lock also guards the region select so a locked window
      // cannot be moved to another region.
      sac_lock_reg #(
        .W      (SAC_WIN_REGION_W),
        .RST    (SAC_WIN_REGION_RST),
        .RETAIN (1'b0)
      ) u_win_region (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .soft_clr_in (soft_reset_in),
        .wr_en_in    (wr_fire && win_region_hit[n]),
        .locked_in   (win_lock_r[n]),
        .wdata_in    (wr_merged[SAC_WIN_REGION_W-1:0]),
        .q_out       (win_region[n])
      );

      sac_lock_reg #(
        .W      (SAC_WIN_SIZE_W),
        .RST    (SAC_WIN_SIZE_RST),
        .RETAIN (1'b0)
      ) u_win_size (
        .ref_clk_in  (ref_clk_in),
        .rst_n_in    (rst_n_in),
        .soft_clr_in (soft_reset_in),
        .wr_en_in    (wr_fire && win_size_hit[n]),
        .locked_in   (win_lock_r[n]),
        .wdata_in    (wr_merged[SAC_WIN_SIZE_W-1:0]),
        .q_out       (win_size[n])
      );

      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          win_lock_r[n] <= 1'b0;
        end else if (soft_reset_in) begin
          win_lock_r[n] <= 1'b0;
        end else if (wr_fire && win_size_hit[n] && wr_merged[SAC_WIN_LOCK_BIT]) begin
          win_lock_r[n] <= 1'b1;
        end
      end

      // Codes above the largest size are stored but treated as no window,
      // which keeps normal attribute enforcement rather than guessing a size.
      always_comb begin
        attr_out.win_region[n] = win_region[n];
        if (win_size[n] == SAC_WIN_SIZE_OFF || win_size[n] > SAC_WIN_SIZE_MAX) begin
          attr_out.win_enable[n] = 1'b0;
          attr_out.win_bytes[n]  = '0;
        end else begin
          attr_out.win_enable[n] = 1'b1;
          attr_out.win_bytes[n]  = SAC_WIN_MIN_BYTES <<
                                   (win_size[n] - SAC_WIN_SIZE_ONE);
        end
      end
    end
  endgenerate

  // Read mux; an unmapped address reads zero and its writes are dropped.
  always_comb begin
    rd_val = '0;
    for (int i = 0; i < SAC_EXT_N; i++) begin
      if (ext_hit[i]) begin
        rd_val[SAC_EXT_CAP_LSB +: SAC_EXT_CAP_W] = EXT_CAPABILITY;
        rd_val[SAC_EXT_ATTR_BIT]                 = ext_attr[i];
        rd_val[SAC_EXT_LOCK_BIT]                 = ext_lock_r[i];
      end
    end
    for (int i = 0; i < SAC_EVT_N; i++) begin
      if (evt_permission_hit[i]) begin
        rd_val[SAC_EVT_CH-1:0] = evt_permission[i];
      end
      if (evt_lock_hit[i]) begin
        rd_val[SAC_LOCK_BIT] = evt_lock_r[i];
      end
    end
    for (int i = 0; i < SAC_PORT_N; i++) begin
      if (port_permission_hit[i]) begin
        rd_val[SAC_PIN_N-1:0] = port_permission[i];
      end
      if (port_lock_hit[i]) begin
        rd_val[SAC_LOCK_BIT] = port_lock_r[i];
      end
    end
    for (int i = 0; i < SAC_WIN_N; i++) begin
      if (win_region_hit[i]) begin
        rd_val[SAC_WIN_REGION_W-1:0] = win_region[i];
      end
      if (win_size_hit[i]) begin
        rd_val[SAC_WIN_SIZE_W-1:0] = win_size[i];
        rd_val[SAC_WIN_LOCK_BIT]   = win_lock_r[i];
      end
    end
  end

endmodule
`default_nettype wire

// ### verification/sac_fabric_model.sv
// Purpose: Bus fabric and pin logic that consume the security attributes.
// Assumes: One external domain; the pin under test is chosen by the bench.
// Notes:   Purely combinational, so it tags accesses with the current levels.
`timescale 1ns/1ps
`default_nettype none
module sac_fabric_model
  import sac_pkg::*;
(
  input  wire sac_attr_t  attr_in,
  input  wire logic       port_sel_in,
  input  wire logic [4:0] pin_in,
  output logic            ext_tag_out,
  output logic            pin_tag_out
);
  assign ext_tag_out = attr_in.ext_secure[0];
  assign pin_tag_out = attr_in.pin_secure[port_sel_in][pin_in];
endmodule
`default_nettype wire

// ### verification/sac_top_properties.sv
// Purpose: Port-level checks of the security attribute configuration block.
// Assumes: One clock; a request sees exactly one wait cycle before it is answered.
// Notes:   Read-back checks tie the register content to the attribute levels it drives.
`timescale 1ns/1ps
`default_nettype none
module sac_top_properties
  import sac_pkg::*;
#(
  parameter sac_cap_t EXT_CAPABILITY = SAC_CAP_SW_SEL
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  soft_reset_in,
  input  wire sac_avm_req_t          avm_req_in,
  input  wire logic                  avm_waitrequest_out,
  input  wire logic [SAC_DATA_W-1:0] avm_readdata_out,
  input  wire sac_attr_t             attr_out
);
  logic                  rd_ok;
  logic                  wr_ok;
  logic                  req_any;
  logic [SAC_ADDR_W-1:0] adr;

  assign rd_ok   = avm_req_in.read && !avm_waitrequest_out;
  assign wr_ok   = avm_req_in.write && !avm_waitrequest_out;
  assign req_any = avm_req_in.read || avm_req_in.write;
  assign adr     = avm_req_in.address;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_one_wait;
    $rose(req_any) |-> avm_waitrequest_out ##1 !avm_waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("request not answered after one wait");

  property p_cap_ro;
    rd_ok && adr == SAC_EXT_PERMISSION_OFS |-> avm_readdata_out[1:0] == EXT_CAPABILITY;
  endproperty
  a_cap_ro: assert property (p_cap_ro) else $error("capability field changed");

  property p_ext_attr;
    rd_ok && adr == SAC_EXT_PERMISSION_OFS |-> attr_out.ext_secure[0] ==
      ((EXT_CAPABILITY == SAC_CAP_SW_SEL) ? avm_readdata_out[4] : (EXT_CAPABILITY == SAC_CAP_SECURE));
  endproperty
  a_ext_attr: assert property (p_ext_attr) else $error("external attribute wrong");

  property p_evt_rb;
    rd_ok && adr == SAC_EVT_PERMISSION_OFS |-> avm_readdata_out == attr_out.evt_secure[0];
  endproperty
  a_evt_rb: assert property (p_evt_rb) else $error("event attribute differs from register");

  property p_pin_rb;
    rd_ok && adr == SAC_PORT_PERMISSION_OFS |-> avm_readdata_out == attr_out.pin_secure[0];
  endproperty
  a_pin_rb: assert property (p_pin_rb) else $error("pin attribute differs from register");

  property p_win_off;
    !attr_out.win_enable[0] |-> attr_out.win_bytes[0] == '0;
  endproperty
  a_win_off: assert property (p_win_off) else $error("disabled window has a size");

  property p_win_pow;
    attr_out.win_enable[0] |-> $onehot(attr_out.win_bytes[0]) &&
      attr_out.win_bytes[0] >= SAC_WIN_MIN_BYTES;
  endproperty
  a_win_pow: assert property (p_win_pow) else $error("window size not a power of two");

  property p_size_rb;
    rd_ok && adr == SAC_WIN_SIZE_OFS |-> attr_out.win_enable[0] ==
      (avm_readdata_out[3:0] >= 4'h1 && avm_readdata_out[3:0] <= 4'h8);
  endproperty
  a_size_rb: assert property (p_size_rb) else $error("window enable disagrees with size");

  property p_quiet;
    !$stable(attr_out) |-> $past(wr_ok) || $past(soft_reset_in);
  endproperty
  a_quiet: assert property (p_quiet) else $error("attributes moved without a write");

  property p_soft_pins;
    soft_reset_in && !wr_ok |=> $stable(attr_out.pin_secure);
  endproperty
  a_soft_pins: assert property (p_soft_pins) else $error("pin attributes lost on soft reset");

  property p_soft_clr;
    soft_reset_in && !wr_ok |=> attr_out.evt_secure == '0 && attr_out.win_enable == '0;
  endproperty
  a_soft_clr: assert property (p_soft_clr) else $error("soft reset left state behind");
endmodule

bind sac_top sac_top_properties #(.EXT_CAPABILITY(EXT_CAPABILITY)) u_sac_top_properties (
  .ref_clk_in          (ref_clk_in),
  .rst_n_in            (rst_n_in),
  .soft_reset_in       (soft_reset_in),
  .avm_req_in          (avm_req_in),
  .avm_waitrequest_out (avm_waitrequest_out),
  .avm_readdata_out    (avm_readdata_out),
  .attr_out            (attr_out)
);
`default_nettype wire

// ### verification/tb_sac_top.sv
// Purpose: Register-level test of the security attribute configuration block.
// Assumes: Avalon-MM slave with waitrequest; the bench waits for each answer, bounded by a limit.
// Notes:   Read data are taken at the rising edge at which waitrequest is sampled low.
`timescale 1ns/1ps
`default_nettype none
module tb_sac_top
  import sac_pkg::*;
;
  logic         ref_clk_in;
  logic         rst_n_in;
  logic         soft_reset_in;
  sac_avm_req_t req;
  logic         waitreq;
  logic [31:0]  rdata;
  sac_attr_t    attr;
  sac_attr_t    attr_sec;
  logic         port_sel;
  logic [4:0]   pin_idx;
  logic         ext_tag;
  logic         pin_tag;
  logic [31:0]  rd;
  int           errors;
  int           samples_checked;

  sac_top #(.EXT_CAPABILITY(SAC_CAP_SW_SEL)) u_sac_top (
    .ref_clk_in          (ref_clk_in),
    .rst_n_in            (rst_n_in),
    .soft_reset_in       (soft_reset_in),
    .avm_req_in          (req),
    .avm_waitrequest_out (waitreq),
    .avm_readdata_out    (rdata),
    .attr_out            (attr)
  );

  // A second copy with the capability fixed to secure, so the fixed path is exercised too.
  sac_top #(.EXT_CAPABILITY(SAC_CAP_SECURE)) u_sac_top_secure (
    .ref_clk_in          (ref_clk_in),
    .rst_n_in            (rst_n_in),
    .soft_reset_in       (soft_reset_in),
    .avm_req_in          (req),
    .avm_waitrequest_out (),
    .avm_readdata_out    (),
    .attr_out            (attr_sec)
  );

  sac_fabric_model u_sac_fabric_model (
    .attr_in     (attr),
    .port_sel_in (port_sel),
    .pin_in      (pin_idx),
    .ext_tag_out (ext_tag),
    .pin_tag_out (pin_tag)
  );

  always #2 ref_clk_in = ~ref_clk_in;

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; returns one edge after release so calls can follow.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req.read       <= !wr;
    req.write      <= wr;
    req.address    <= a;
    req.writedata  <= d;
    req.byteenable <= 4'hF;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    rd = rdata;
    if (waitreq !== 1'b0) begin
      check(32'(waitreq), 32'h0);
    end
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge ref_clk_in);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    errors++;
    final_report();
  end

  initial begin
    ref_clk_in = 1'b0;
    rst_n_in = 1'b0;
    soft_reset_in = 1'b0;
    req = '0;
    port_sel = 1'b0;
    pin_idx = 5'h1F;
    errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    rdchk(12'h440, 32'h00000002);
    rdchk(12'h504, 32'h00000000);
    check(32'(attr.ext_secure), 32'h0);
    check(32'(attr_sec.ext_secure), 32'h1);
    $display("test reset_values done");
    wr(12'h440, 32'h00000013);
    rdchk(12'h440, 32'h00000012);
    check(32'(ext_tag), 32'h1);
    wr(12'h440, 32'h00000000);
    check(32'(ext_tag), 32'h0);
    check(32'(attr_sec.ext_secure), 32'h1);
    wr(12'h440, 32'h00000110);
    wr(12'h440, 32'h00000000);
    rdchk(12'h440, 32'h00000112);
    check(32'(ext_tag), 32'h1);
    $display("test external_domain done");
    wr(12'h480, 32'hA5A5A5A5);
    check(attr.evt_secure[0], 32'hA5A5A5A5);
    wr(12'h484, 32'h00000000);
    wr(12'h480, 32'h0000000F);
    rdchk(12'h480, 32'h0000000F);
    wr(12'h484, 32'h00000001);
    wr(12'h480, 32'hFFFFFFFF);
    check(attr.evt_secure[0], 32'h0000000F);
    rdchk(12'h484, 32'h00000001);
    $display("test event_channels done");
    for (int p = 0; p < 2; p++) begin
      port_sel <= p[0];
      wr(12'h4C0 + 12'(8 * p), p ? 32'h7FFFFFFE : 32'h80000001);
      check(32'(pin_tag), p ? 32'h0 : 32'h1);
      check(attr.pin_secure[p], p ? 32'h7FFFFFFE : 32'h80000001);
    end
    wr(12'h4C4, 32'h00000001);
    wr(12'h4C0, 32'h00000000);
    check(attr.pin_secure[0], 32'h80000001);
    wr(12'h4C8, 32'h12345678);
    check(attr.pin_secure[1], 32'h12345678);
    $display("test port_pins done");
    for (int c = 0; c < 10; c++) begin
      wr(12'h504, 32'(c));
      check(32'(attr.win_bytes[0]), (c == 0 || c > 8) ? 32'h0 : 32'h10 << c);
      check(32'(attr.win_enable[0]), 32'((c > 0) && (c < 9)));
    end
    wr(12'h500, 32'h0000002A);
    check(32'(attr.win_region[0]), 32'h0000002A);
    wr(12'h50C, 32'h00000103);
    wr(12'h50C, 32'h00000001);
    check(32'(attr.win_bytes[1]), 32'h00000080);
    rdchk(12'h50C, 32'h00000103);
    wr(12'h600, 32'hFFFFFFFF);
    rdchk(12'h600, 32'h00000000);
    $display("test callable_windows done");
    soft_reset_in <= 1'b1;
    @(posedge ref_clk_in);
    soft_reset_in <= 1'b0;
    @(posedge ref_clk_in);
    rdchk(12'h4C0, 32'h80000001);
    rdchk(12'h484, 32'h00000000);
    rdchk(12'h440, 32'h00000002);
    wr(12'h480, 32'h0000003C);
    check(attr.evt_secure[0], 32'h0000003C);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    rdchk(12'h50C, 32'h00000000);
    rdchk(12'h4C0, 32'h00000000);
    $display("test resets done");
    final_report();
  end
endmodule
`default_nettype wire
